//--- logic/sgp_pkg.sv
// Package for the shared port block: register map, field positions, reset values, carriers.
// Assumes a 32-bit AXI4-Lite register bus with byte address = 4 * register index.
package sgp_pkg;

    // ==========================================================
    // Register indices and bus constants
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_PORTC = 6'h02;
    localparam logic [IDX_W-1:0] IDX_PORTD = 6'h03;
    localparam logic [IDX_W-1:0] IDX_PC_DIR = 6'h06;
    localparam logic [IDX_W-1:0] IDX_PD_DIR = 6'h07;
    localparam logic [IDX_W-1:0] IDX_PORTE = 6'h08;
    localparam logic [IDX_W-1:0] IDX_PE_DIR = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_PERCFG = 6'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Field positions
    localparam int PC_W = 6;
    localparam int PD_W = 8;
    localparam int PE_W = 8;
    localparam int MCLK_EN_BIT = 7;
    localparam int MCLK_PIN = 2;
    localparam int TA_CLK_PIN = 6;
    localparam int TB_CLK_PIN = 4;
    localparam int ADC_PINS = 7;
    localparam logic [4:0] ADC_BASE_CHAN = 5'h08;
    localparam int SCK_PIN = 7;
    localparam int MOSI_PIN = 6;
    localparam int MISO_PIN = 5;
    localparam int SS_PIN = 4;
    localparam int TCH1_PIN = 3;
    localparam int TCH0_PIN = 2;
    localparam int RXD_PIN = 1;
    localparam int TXD_PIN = 0;
    localparam logic [2:0] PRESC_EXT_CLK = 3'h7;
    localparam logic [1:0] ELS_OFF = 2'h0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DDR_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_DIR_RST = 6'h00;
    localparam logic MCLK_EN_RST = 1'b0;
    localparam int CFG_W = 19;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic sci_enable_bit;
        logic [1:0] ch1_edge_level_select;
        logic [1:0] ch0_edge_level_select;
        logic mode_fault_enable;
        logic spi_master_bit;
        logic spi_enable_bit;
        logic [2:0] tb_prescaler_select;
        logic [2:0] ta_prescaler_select;
        logic [4:0] adc_channel_select;
    } sgp_cfg_s;

    localparam sgp_cfg_s CFG_RST = '0;

    // Peripheral drive toward the pins
    typedef struct packed {
        logic spi_sck;
        logic spi_mosi;
        logic spi_miso;
        logic [1:0] tch_out;
        logic [1:0] tch_oe;
        logic sci_txd;
    } sgp_per_out_s;

    // Synchronised pin levels toward the peripherals
    typedef struct packed {
        logic timer_a_ext_clock;
        logic timer_b_ext_clock;
        logic spi_sck;
        logic spi_mosi;
        logic spi_miso;
        logic spi_ss;
        logic [1:0] tch_in;
        logic sci_rxd;
    } sgp_per_in_s;

endpackage : sgp_pkg

//--- logic/sgp_sync2.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes each bit is an independent level; no multi-bit coherence is needed.
module sgp_sync2 #(
    parameter int W = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ==========================================================
    // First stage is read only by the second
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // sgp_sync2

//--- logic/sgp_gpio_ports.sv
// Three shared ports (6, 8 and 8 bits) with latches, direction bits and peripheral takeover.
// Assumes an AXI4-Lite master on i_core_clk and peripherals on the same clock.
//
// Contract
// - Six-bit port keeps six read/write latch bits; reset leaves them unchanged.
// - Clock-output enable bit drives system clock onto six-bit port pin 2.
// - Clock output enabled overrides pin 2 direction; reset clears clock-output enable.
// - Direction one enables output buffer; reset clears six-bit port directions.
// - Six-bit port read gives latch where direction one, pin level otherwise; pin 2 reads zero while clock output enabled.
// - Latches always writable; writing an input's latch leaves pin reading unchanged.
// - Reset clears all first eight-bit port direction bits.
// - First eight-bit port read gives latch or pin level by direction.
// - ADC-selected first-port pin reads zero as input, latch as output.
// - Timer-owned pins ignore first-port direction, which still selects read source.
// - First-port pins 6 and 4 are timer clock inputs when prescaler selects them.
// - Second-port pins 7, 6, 5 carry SPI clock, MOSI, MISO when SPI enabled.
// - Pin 4 is GPIO if SPI off or master without mode fault; else select.
// - SPI slave mode makes slave-select pin direction bit ineffective.
// - Peripheral-owned second-port pins ignore direction; direction still picks read source.
// - Second-port pins 3, 2 are timer channels when edge/level select nonzero.
// - Second-port pins 1, 0 are SCI receive and transmit when SCI enabled.
// - Six-bit port data at index 2; upper two bits read zero.
//
// Implementation choice: register access over AXI4-Lite.
module sgp_gpio_ports import sgp_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic [PC_W-1:0] i_pc_pin,
    output logic [PC_W-1:0] o_pc_pin,
    output logic [PC_W-1:0] o_pc_oe,
    input wire logic [PD_W-1:0] i_pd_pin,
    output logic [PD_W-1:0] o_pd_pin,
    output logic [PD_W-1:0] o_pd_oe,
    input wire logic [PE_W-1:0] i_pe_pin,
    output logic [PE_W-1:0] o_pe_pin,
    output logic [PE_W-1:0] o_pe_oe,
    input wire logic i_mclk,
    input wire sgp_per_out_s i_per,
    output sgp_per_in_s o_per,
    output sgp_cfg_s o_cfg
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    // ==========================================================
    // State
    logic aw_held_reg;
    logic [IDX_W-1:0] widx_reg;
    logic w_held_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [PC_W-1:0] pc_latch_reg;
    logic [PD_W-1:0] pd_latch_reg;
    logic [PE_W-1:0] pe_latch_reg;
    logic [PC_W-1:0] pc_dir_reg;
    logic mclk_en_reg;
    logic [PD_W-1:0] pd_dir_reg;
    logic [PE_W-1:0] pe_dir_reg;
    sgp_cfg_s cfg_reg;
    logic [PC_W-1:0] pc_sync;
    logic [PD_W-1:0] pd_sync;
    logic [PE_W-1:0] pe_sync;

    // ==========================================================
    // Pin synchronisers
    sgp_sync2 #(.W(PC_W)) u_sync_pc (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pc_pin),
        .o_sync(pc_sync)
    );
    sgp_sync2 #(.W(PD_W)) u_sync_pd (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pd_pin),
        .o_sync(pd_sync)
    );
    sgp_sync2 #(.W(PE_W)) u_sync_pe (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pe_pin),
        .o_sync(pe_sync)
    );

    // ==========================================================
    // Bus decode
    wire logic aw_take = i_awvalid && o_awready;
    wire logic w_take = i_wvalid && o_wready;
    wire logic wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire logic rd_fire = i_arvalid && o_arready;
    wire logic [IDX_W-1:0] ridx = i_araddr[ADDR_W-1:2];
    wire logic wr_en = wr_fire && wstrb0_reg;
    wire logic [PC_W-1:0] pc_wr_val = wdata_reg[PC_W-1:0];
    wire logic wr_mapped = (widx_reg == IDX_PORTC) || (widx_reg == IDX_PORTD)
        || (widx_reg == IDX_PC_DIR) || (widx_reg == IDX_PD_DIR) || (widx_reg == IDX_PORTE)
        || (widx_reg == IDX_PE_DIR) || (widx_reg == IDX_PERCFG);

    assign o_awready = !aw_held_reg && !bvalid_reg;
    assign o_wready = !w_held_reg && !bvalid_reg;
    assign o_arready = !rvalid_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;

    // ==========================================================
    // Pin ownership
    wire logic ta_own = cfg_reg.ta_prescaler_select == PRESC_EXT_CLK;
    wire logic tb_own = cfg_reg.tb_prescaler_select == PRESC_EXT_CLK;
    wire logic spi_on = cfg_reg.spi_enable_bit;
    wire logic spi_mst = cfg_reg.spi_master_bit;
    wire logic ss_own = spi_on && !(spi_mst && !cfg_reg.mode_fault_enable);
    wire logic sci_on = cfg_reg.sci_enable_bit;
    wire logic [1:0] tch_own = {cfg_reg.ch1_edge_level_select != ELS_OFF,
        cfg_reg.ch0_edge_level_select != ELS_OFF};
    logic [PD_W-1:0] adc_sel;
    wire logic [PD_W-1:0] tclk_own = {1'b0, ta_own, 1'b0, tb_own, 4'h0};

    genvar k;
    generate
        for (k = 0; k < PD_W; k++) begin : g_adc
            if (k < ADC_PINS) begin : g_ch
                assign adc_sel[k] = cfg_reg.adc_channel_select == (ADC_BASE_CHAN + 5'(k));
            end else begin : g_none
                assign adc_sel[k] = 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // Pin drive
    always_comb begin
        o_pc_pin = pc_latch_reg;
        o_pc_oe = pc_dir_reg;
        if (mclk_en_reg) begin
            o_pc_pin[MCLK_PIN] = i_mclk;
            o_pc_oe[MCLK_PIN] = 1'b1;
        end
    end

    // ADC and timer clock pins are released; direction still steers reads
    assign o_pd_pin = pd_latch_reg;
    assign o_pd_oe = pd_dir_reg & ~adc_sel & ~tclk_own;

    always_comb begin
        o_pe_pin = pe_latch_reg;
        o_pe_oe = pe_dir_reg;
        if (spi_on) begin
            o_pe_pin[SCK_PIN] = i_per.spi_sck;
            o_pe_oe[SCK_PIN] = spi_mst;
            o_pe_pin[MOSI_PIN] = i_per.spi_mosi;
            o_pe_oe[MOSI_PIN] = spi_mst;
            o_pe_pin[MISO_PIN] = i_per.spi_miso;
            o_pe_oe[MISO_PIN] = !spi_mst;
        end
        if (ss_own) begin
            o_pe_oe[SS_PIN] = 1'b0;
        end
        if (tch_own[1]) begin
            o_pe_pin[TCH1_PIN] = i_per.tch_out[1];
            o_pe_oe[TCH1_PIN] = i_per.tch_oe[1];
        end
        if (tch_own[0]) begin
            o_pe_pin[TCH0_PIN] = i_per.tch_out[0];
            o_pe_oe[TCH0_PIN] = i_per.tch_oe[0];
        end
        if (sci_on) begin
            o_pe_oe[RXD_PIN] = 1'b0;
            o_pe_pin[TXD_PIN] = i_per.sci_txd;
            o_pe_oe[TXD_PIN] = 1'b1;
        end
    end

    assign o_per.timer_a_ext_clock = pd_sync[TA_CLK_PIN];
    assign o_per.timer_b_ext_clock = pd_sync[TB_CLK_PIN];
    assign o_per.spi_sck = pe_sync[SCK_PIN];
    assign o_per.spi_mosi = pe_sync[MOSI_PIN];
    assign o_per.spi_miso = pe_sync[MISO_PIN];
    assign o_per.spi_ss = pe_sync[SS_PIN];
    assign o_per.tch_in = {pe_sync[TCH1_PIN], pe_sync[TCH0_PIN]};
    assign o_per.sci_rxd = pe_sync[RXD_PIN];
    assign o_cfg = cfg_reg;

    // ==========================================================
    // Read data selection
    wire logic [PC_W-1:0] pc_mask = mclk_en_reg ? ~(PC_W'(1) << MCLK_PIN) : '1;
    wire logic [PC_W-1:0] pc_rd = ((pc_dir_reg & pc_latch_reg) | (~pc_dir_reg & pc_sync))
        & pc_mask;
    wire logic [PD_W-1:0] pd_rd = (pd_dir_reg & pd_latch_reg)
        | (~pd_dir_reg & ~adc_sel & pd_sync);
    wire logic [PE_W-1:0] pe_rd = (pe_dir_reg & pe_latch_reg)
        | (~pe_dir_reg & pe_sync);
    logic [31:0] rd_mux;
    logic rd_ok;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (ridx)
            IDX_PORTC: rd_mux = {26'h000_0000, pc_rd};
            IDX_PORTD: rd_mux = {24'h00_0000, pd_rd};
            IDX_PC_DIR: rd_mux = {24'h00_0000, mclk_en_reg, 1'b0, pc_dir_reg};
            IDX_PD_DIR: rd_mux = {24'h00_0000, pd_dir_reg};
            IDX_PORTE: rd_mux = {24'h00_0000, pe_rd};
            IDX_PE_DIR: rd_mux = {24'h00_0000, pe_dir_reg};
            IDX_PERCFG: rd_mux = {13'h0000, cfg_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Bus handshake state
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_held_reg <= 1'b0;
            widx_reg <= '0;
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                widx_reg <= i_awaddr[ADDR_W-1:2];
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg <= i_wdata;
                wstrb0_reg <= i_wstrb[0];
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (i_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pc_dir_reg <= PC_DIR_RST;
            mclk_en_reg <= MCLK_EN_RST;
            pd_dir_reg <= DDR_RST;
            pe_dir_reg <= DDR_RST;
            cfg_reg <= CFG_RST;
        end else if (wr_en) begin
            if (widx_reg == IDX_PC_DIR) begin
                pc_dir_reg <= wdata_reg[PC_W-1:0];
                mclk_en_reg <= wdata_reg[MCLK_EN_BIT];
            end
            if (widx_reg == IDX_PD_DIR) begin
                pd_dir_reg <= wdata_reg[PD_W-1:0];
            end
            if (widx_reg == IDX_PE_DIR) begin
                pe_dir_reg <= wdata_reg[PE_W-1:0];
            end
            if (widx_reg == IDX_PERCFG) begin
                cfg_reg <= sgp_cfg_s'(wdata_reg[CFG_W-1:0]);
            end
        end
    end

    // Data latches have no reset so contents survive it
    always_ff @(posedge i_core_clk) begin
        if (wr_en && widx_reg == IDX_PORTC) begin
            pc_latch_reg <= pc_wr_val;
        end
        if (wr_en && widx_reg == IDX_PORTD) begin
            pd_latch_reg <= wdata_reg[PD_W-1:0];
        end
        if (wr_en && widx_reg == IDX_PORTE) begin
            pe_latch_reg <= wdata_reg[PE_W-1:0];
        end
    end

    // ==========================================================
    // Checks
    mclk_drive_a: assert property (mclk_en_reg |-> (o_pc_oe[2] && o_pc_pin[2] == i_mclk))
        else $error("clock output not on pin 2");
    mclk_ddr_ignore_a: assert property ((mclk_en_reg && !pc_dir_reg[2]) |-> o_pc_oe[2])
        else $error("pin 2 direction not overridden");
    pc_dir_a: assert property (!mclk_en_reg |-> (o_pc_oe == pc_dir_reg))
        else $error("six-bit port enables differ from direction");
    pc_read_a: assert property ((rd_fire && ridx == IDX_PORTC && !mclk_en_reg) |=>
        (o_rvalid && o_rdata[5:0] == (($past(pc_dir_reg) & $past(pc_latch_reg))
        | (~$past(pc_dir_reg) & $past(pc_sync)))))
        else $error("six-bit port read wrong");
    pc_upper_a: assert property ((rd_fire && ridx == IDX_PORTC) |=>
        (o_rdata[31:6] == 26'h000_0000 && o_rresp == RESP_OKAY))
        else $error("six-bit port upper bits not zero");
    mclk_read_a: assert property ((rd_fire && ridx == IDX_PORTC && mclk_en_reg) |=>
        !o_rdata[2])
        else $error("pin 2 reads nonzero under clock output");
    latch_write_a: assert property ((wr_en && widx_reg == IDX_PORTC) |=>
        (pc_latch_reg == $past(pc_wr_val) && o_bvalid))
        else $error("six-bit latch write lost");
    pd_read_a: assert property ((rd_fire && ridx == IDX_PORTD && adc_sel == 8'h00) |=>
        (o_rdata[7:0] == (($past(pd_dir_reg) & $past(pd_latch_reg))
        | (~$past(pd_dir_reg) & $past(pd_sync)))))
        else $error("first port read wrong");
    adc_zero_a: assert property ((rd_fire && ridx == IDX_PORTD) |=>
        ((o_rdata[7:0] & $past(adc_sel) & ~$past(pd_dir_reg)) == 8'h00))
        else $error("ADC input pin read not zero");
    tclk_in_a: assert property ((ta_own || tb_own) |->
        ((!ta_own || !o_pd_oe[6]) && (!tb_own || !o_pd_oe[4])))
        else $error("timer clock pin driven");
    spi_pins_a: assert property ((spi_on && spi_mst) |->
        (o_pe_oe[7:5] == 3'h6 && o_pe_pin[7] == i_per.spi_sck))
        else $error("SPI master pins wrong");
    ss_input_a: assert property ((spi_on && !spi_mst) |-> !o_pe_oe[4])
        else $error("slave select driven in slave mode");
    tch_pins_a: assert property (tch_own[0] |-> (o_pe_oe[2] == i_per.tch_oe[0]))
        else $error("timer channel enable wrong");
    sci_pins_a: assert property (sci_on |->
        (!o_pe_oe[1] && o_pe_oe[0] && o_pe_pin[0] == i_per.sci_txd))
        else $error("SCI pins wrong");

    cov_clk_out_wr: cover property (wr_en && widx_reg == IDX_PC_DIR && wdata_reg[MCLK_EN_BIT]);
    cov_adc_rd: cover property (rd_fire && ridx == IDX_PORTD && adc_sel != 8'h00);
    cov_spi_slave: cover property (spi_on && !spi_mst && pe_dir_reg[SS_PIN]);
endmodule // sgp_gpio_ports

//--- verification/sgp_pin_model.sv
// Board side of one port: external drivers and the resolved pin level.
// Assumes no pull resistors; a floating pin shows a level that flips each cycle.
module sgp_pin_model #(
    parameter int W = 8
) (
    input wire logic i_core_clk,
    input wire logic [W-1:0] i_dev_oe,
    input wire logic [W-1:0] i_dev_pin,
    input wire logic [W-1:0] i_brd_en,
    input wire logic [W-1:0] i_brd_val,
    output logic [W-1:0] o_level
);
    // ==========================================
    // Wire level
    logic flip_reg = 1'b0;
    always @(posedge i_core_clk) begin
        flip_reg <= ~flip_reg;
    end
    // Floating pins never hold a stale value, so a missed drive is seen
    assign o_level = (i_dev_oe & i_dev_pin) | (~i_dev_oe & i_brd_en & i_brd_val)
        | (~i_dev_oe & ~i_brd_en & {W{flip_reg}});
endmodule // sgp_pin_model

//--- verification/sgp_gpio_ports_tb_top.sv
// Bench for the shared port block: bus tasks, one task per scenario, verdict.
// Assumes the pin model on every port and a 40 MHz core clock.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected t=%0t got %0h want %0h", $time, g, e); end end
module sgp_gpio_ports_tb_top import sgp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic mclk = 1'b0;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [PC_W-1:0] pc_i, pc_o, pc_oe, pc_be = '0, pc_bv = '0;
    logic [PD_W-1:0] pd_i, pd_o, pd_oe, pd_be = '0, pd_bv = '0;
    logic [PE_W-1:0] pe_i, pe_o, pe_oe;
    sgp_per_out_s per = '0;
    sgp_per_in_s per_in;
    sgp_cfg_s cfg;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    // ==========================================
    // Clocks, timeout, instances
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        mclk <= ~mclk;
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            finish_test();
        end
    end
    sgp_gpio_ports u_sgp_gpio_ports (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_awvalid(awv), .o_awready(aw_rdy), .i_awaddr(awa), .i_wvalid(wv),
        .o_wready(w_rdy), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(b_vld),
        .i_bready(1'b1), .o_bresp(bresp), .i_arvalid(arv), .o_arready(ar_rdy),
        .i_araddr(ara), .o_rvalid(r_vld), .i_rready(1'b1), .o_rdata(rdata),
        .o_rresp(rresp), .i_pc_pin(pc_i), .o_pc_pin(pc_o), .o_pc_oe(pc_oe),
        .i_pd_pin(pd_i), .o_pd_pin(pd_o), .o_pd_oe(pd_oe), .i_pe_pin(pe_i),
        .o_pe_pin(pe_o), .o_pe_oe(pe_oe), .i_mclk(mclk), .i_per(per),
        .o_per(per_in), .o_cfg(cfg));
    sgp_pin_model #(.W(PC_W)) u_pins_c (.i_core_clk(clk), .i_dev_oe(pc_oe),
        .i_dev_pin(pc_o), .i_brd_en(pc_be), .i_brd_val(pc_bv), .o_level(pc_i));
    sgp_pin_model #(.W(PD_W)) u_pins_d (.i_core_clk(clk), .i_dev_oe(pd_oe),
        .i_dev_pin(pd_o), .i_brd_en(pd_be), .i_brd_val(pd_bv), .o_level(pd_i));
    sgp_pin_model #(.W(PE_W)) u_pins_e (.i_core_clk(clk), .i_dev_oe(pe_oe),
        .i_dev_pin(pe_o), .i_brd_en(8'h00), .i_brd_val(8'h00), .o_level(pe_i));
    // ==========================================
    // Bus tasks; handshakes judged at the falling edge, acted on at the rising one
    task automatic wr(input logic [IDX_W-1:0] ix, input logic [31:0] d,
        input logic [1:0] er = RESP_OKAY);
        logic ha = 1'b0, hw = 1'b0, hb = 1'b0;
        awa <= {ix, 2'b00};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!hb) begin
            @(negedge clk);
            ha = awv & aw_rdy;
            hw = wv & w_rdy;
            hb = b_vld;
            if (hb) `CHK(bresp, er)
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
        end
    endtask
    task automatic rc(input logic [IDX_W-1:0] ix, input logic [31:0] e,
        input logic [1:0] er = RESP_OKAY);
        logic ha = 1'b0, hr = 1'b0;
        ara <= {ix, 2'b00};
        arv <= 1'b1;
        while (!hr) begin
            @(negedge clk);
            ha = arv & ar_rdy;
            hr = r_vld;
            if (hr) begin
                `CHK(rdata, e)
                `CHK(rresp, er)
            end
            @(posedge clk);
            if (ha) arv <= 1'b0;
        end
    endtask
    task automatic chk_e(input logic [7:0] oe, input logic [7:0] pv);
        @(negedge clk);
        `CHK(pe_oe, oe)
        `CHK(pe_o & oe, pv)
        @(posedge clk);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        rc(IDX_PC_DIR, 32'h0000_0000);
        rc(IDX_PD_DIR, 32'h0000_0000);
        @(negedge clk);
        `CHK({pc_oe, pd_oe, pe_oe}, 22'h0)
        @(posedge clk);
    endtask
    task automatic t_portc;
        pc_bv <= 6'h10;
        pc_be <= 6'h30;
        wr(IDX_PORTC, 32'h0000_002A);
        wr(IDX_PC_DIR, 32'h0000_000F);
        rc(IDX_PORTC, 32'h0000_001A);
        wr(IDX_PORTC, 32'h0000_003E);
        rc(IDX_PORTC, 32'h0000_001E);
        @(negedge clk);
        `CHK(pc_oe, 6'h0F)
        `CHK(pc_o[3:0], 4'hE)
        @(posedge clk);
    endtask
    task automatic t_mclk;
        wr(IDX_PC_DIR, 32'h0000_0080);
        @(negedge clk);
        `CHK(pc_oe, 6'h04)
        `CHK(pc_o[2], mclk)
        @(negedge clk);
        `CHK(pc_o[2], mclk)
        @(posedge clk);
        wr(IDX_PC_DIR, 32'h0000_00FF);
        rc(IDX_PC_DIR, 32'h0000_00BF);
        rc(IDX_PORTC, 32'h0000_003A);
    endtask
    task automatic t_keep;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rc(IDX_PC_DIR, 32'h0000_0000);
        wr(IDX_PC_DIR, 32'h0000_003F);
        rc(IDX_PORTC, 32'h0000_003E);
    endtask
    task automatic t_portd;
        pd_bv <= 8'h46;
        pd_be <= 8'h4F;
        wr(IDX_PORTD, 32'h0000_00A3);
        wr(IDX_PD_DIR, 32'h0000_00F0);
        rc(IDX_PORTD, 32'h0000_00A6);
        wr(IDX_PERCFG, 32'h0000_0009);
        rc(IDX_PORTD, 32'h0000_00A4);
        wr(IDX_PERCFG, 32'h0000_07E0);
        rc(IDX_PORTD, 32'h0000_00A6);
        @(negedge clk);
        `CHK(pd_oe, 8'hA0)
        `CHK(per_in.timer_a_ext_clock, 1'b1)
        `CHK(pd_o, 8'hA3)
        `CHK(cfg, 19'h0_07E0)
        @(posedge clk);
    endtask
    task automatic t_porte;
        per <= sgp_per_out_s'(8'hAB);
        wr(IDX_PORTE, 32'h0000_005A);
        wr(IDX_PE_DIR, 32'h0000_00FF);
        wr(IDX_PERCFG, 32'h0000_1800);
        chk_e(8'hDF, 8'h9A);
        wr(IDX_PERCFG, 32'h0000_3800);
        chk_e(8'hCF, 8'h8A);
        wr(IDX_PERCFG, 32'h0005_4800);
        chk_e(8'h25, 8'h25);
        rc(IDX_PORTE, 32'h0000_005A);
        wr(IDX_PERCFG, 32'h0000_0000);
        chk_e(8'hFF, 8'h5A);
        @(negedge clk);
        `CHK(per_in[6:0], 7'h2D)
        @(posedge clk);
    endtask
    task automatic t_unmapped;
        wr(6'h11, 32'h0000_00FF, RESP_SLVERR);
        rc(6'h11, 32'h0000_0000, RESP_SLVERR);
    endtask
    // ==========================================
    // Sequence and verdict
    task automatic finish_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_portc();
        t_mclk();
        t_keep();
        t_portd();
        t_porte();
        t_unmapped();
        finish_test();
    end
endmodule // sgp_gpio_ports_tb_top
